// *** src/decoder_defs.svh ***
// Purpose: constants for the 14-bit instruction decoder
// Assumes: one clock at 10 MHz; one instruction cycle is four clock periods
// Notes: field positions, opcode nibbles and reset values
//
// Contract
// - Each instruction is one 14-bit word: opcode plus operand fields.
// - Byte ops: destination 0 writes accumulator, 1 writes the file register.
// - File address is a seven-bit field, 0x00 to 0x7F.
// - Bit ops carry a three-bit bit number within the 8-bit register.
// - Literal ops carry eight bits; call and jump carry eleven, bit 11 selects.
// - One cycle each; two when a test is true or PC changes.
// - One instruction cycle is exactly four oscillator periods.
// - Add, subtract update C, DC, Z; AND, OR, XOR update Z only.
// - Inc, dec, complement, move update Z; rotates update C; swap none.
// - Decrement or increment and skip on zero; two cycles then; no flags.
// - Bit clear, set, skip-if-clear, skip-if-set; no flags changed.
// - Literal add, subtract, AND, OR, XOR, load with register-form flags; the decoder's literal load changes no flag.
// - Return with literal loads accumulator and returns, two cycles.
// - Words ending 1000 and 1001 return and return from interrupt, two cycles.
// - Watchdog clear word affects timeout and powerdown flags, one cycle.
// - Standby word affects timeout and powerdown flags, one cycle.
// - Don't-care bits are ignored when decoding.
// - A met skip discards the fetched next word and runs a no-operation.
`ifndef DECODER_DEFS_SVH
`define DECODER_DEFS_SVH

`define INSN_W 14
`define PREFIX_HI 13
`define PREFIX_LO 12
`define NIB_HI 11
`define NIB_LO 8
`define DEST_BIT 7
`define FILE_HI 6
`define BIT_HI 9
`define BIT_LO 7
`define JUMP_SEL_BIT 11
`define TARGET_HI 10

`define PFX_BYTE 2'h0
`define PFX_BIT 2'h1
`define PFX_CTRL 2'h2
`define PFX_LIT 2'h3

`define NIB_MISC 4'h0
`define NIB_CLR 4'h1
`define NIB_SUB 4'h2
`define NIB_DEC 4'h3
`define NIB_OR 4'h4
`define NIB_AND 4'h5
`define NIB_XOR 4'h6
`define NIB_ADD 4'h7
`define NIB_MOV 4'h8
`define NIB_COM 4'h9
`define NIB_INC 4'hA
`define NIB_DECSZ 4'hB
`define NIB_RRC 4'hC
`define NIB_RLC 4'hD
`define NIB_SWAP 4'hE
`define NIB_INCSZ 4'hF

`define WORD_RETURN 14'h0008
`define WORD_RETFI 14'h0009
`define WORD_WDCLR 14'h0064
`define WORD_STANDBY 14'h0063

`define PHASES_PER_CYCLE 3'h4
`define PHASE_LAST 2'h3
`define NOP_WORD 14'h0000
`endif

// *** src/decoder_pkg.sv ***
package decoder_pkg;
  typedef enum logic [4:0] {
    OP_NOP = 5'b00000, OP_ADD = 5'b00001, OP_SUB = 5'b00010, OP_AND = 5'b00011,
    OP_OR = 5'b00100, OP_XOR = 5'b00101, OP_INC = 5'b00110, OP_DEC = 5'b00111,
    OP_COM = 5'b01000, OP_MOV = 5'b01001, OP_RLC = 5'b01010, OP_RRC = 5'b01011,
    OP_SWAP = 5'b01100, OP_CLR = 5'b01101, OP_MOVWF = 5'b01110, OP_BCLR = 5'b01111,
    OP_BSET = 5'b10000, OP_BTSTC = 5'b10001, OP_BTSTS = 5'b10010, OP_LOAD = 5'b10011,
    OP_CALL = 5'b10100, OP_JUMP = 5'b10101, OP_RET = 5'b10110, OP_RETLIT = 5'b10111,
    OP_RETFI = 5'b11000, OP_WDCLR = 5'b11001, OP_SLEEP = 5'b11010, OP_ILLEGAL = 5'b11111
  } op_e;
  typedef enum logic [1:0] {
    SRC_REG = 2'b00, SRC_LIT = 2'b01, SRC_NONE = 2'b10
  } src_e;
  typedef enum logic [1:0] {
    EX_IDLE = 2'b00, EX_RUN = 2'b01, EX_FLUSH = 2'b10
  } exec_e;
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
    logic timeout_flag;
    logic powerdown_flag;
  } flags_s;
  typedef struct packed {
    op_e op;
    src_e src;
    logic dest_reg;
    logic dest_acc;
    logic [6:0] file_addr;
    logic [2:0] bit_sel;
    logic [7:0] literal;
    logic [10:0] target;
    logic skip_on_zero;
    logic two_cycle;
    flags_s affects;
  } decode_s;
endpackage

// *** src/insn_latch.sv ***
// Purpose: holds the instruction word being decoded for one instruction cycle
// Assumes: load is a one-cycle pulse at the end of an instruction cycle
// Notes: a squash load stores the no-operation word instead of the fetched one
`timescale 1ns/1ps
`include "decoder_defs.svh"
module insn_latch (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic squash_in,
  input wire logic [`INSN_W-1:0] word_in,
  output logic [`INSN_W-1:0] word_out
);
  logic [`INSN_W-1:0] word_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_r <= `NOP_WORD;
    end else if (load_in) begin
      word_r <= squash_in ? `NOP_WORD : word_in;
    end
  end
  assign word_out = word_r;
endmodule

// *** src/insn_decoder.sv ***
// Purpose: decodes 14-bit instruction words and sequences one or two cycle execution
// Assumes: fetch word valid when the cycle strobe is high; skip result comes from the datapath
// Notes: all outputs registered; decode results change once per instruction cycle
`timescale 1ns/1ps
`include "decoder_defs.svh"
module insn_decoder
  import decoder_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Program memory side
  input wire logic [`INSN_W-1:0] fetch_word_in,
  output logic fetch_take_out,
  // Datapath feedback
  input wire logic result_zero_in,
  input wire logic tested_bit_in,
  // Decoded instruction
  output decode_s decode_out,
  output logic execute_out,
  output logic nop_cycle_out,
  output logic cycle_end_out,
  output logic [1:0] phase_out
);

  typedef struct packed {
    logic [1:0] phase;
    exec_e ex;
    decode_s dec;
    logic execute;
    logic nop_cycle;
    logic cycle_end;
    logic take;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic [`INSN_W-1:0] cur_word;
  logic load_word;
  logic squash_next;

  function automatic flags_s fl(input logic c, input logic dc, input logic z, input logic tp);
    flags_s f;
    f.carry = c;
    f.digit_carry_flag = dc;
    f.zero = z;
    f.timeout_flag = tp;
    f.powerdown_flag = tp;
    return f;
  endfunction

  function automatic decode_s decode(input logic [`INSN_W-1:0] w);
    decode_s d;
    logic [3:0] nib;
    d = '0;
    nib = w[`NIB_HI:`NIB_LO];
    d.op = OP_ILLEGAL;
    d.src = SRC_NONE;
    d.file_addr = w[`FILE_HI:0];
    d.bit_sel = w[`BIT_HI:`BIT_LO];
    d.literal = w[7:0];
    d.target = w[`TARGET_HI:0];
    unique case (w[`PREFIX_HI:`PREFIX_LO])
      `PFX_BYTE: begin
        d.src = SRC_REG;
        d.dest_reg = w[`DEST_BIT];
        d.dest_acc = ~w[`DEST_BIT];
        unique case (nib)
          `NIB_ADD: begin
            d.op = OP_ADD;
            d.affects = fl(1'b1, 1'b1, 1'b1, 1'b0);
          end
          `NIB_SUB: begin
            d.op = OP_SUB;
            d.affects = fl(1'b1, 1'b1, 1'b1, 1'b0);
          end
          `NIB_AND: begin
            d.op = OP_AND;
            d.affects = fl(1'b0, 1'b0, 1'b1, 1'b0);
          end
          `NIB_OR: begin
            d.op = OP_OR;
            d.affects = fl(1'b0, 1'b0, 1'b1, 1'b0);
          end
          `NIB_XOR: begin
            d.op = OP_XOR;
            d.affects = fl(1'b0, 1'b0, 1'b1, 1'b0);
          end
          `NIB_INC: begin
            d.op = OP_INC;
            d.affects = fl(1'b0, 1'b0, 1'b1, 1'b0);
          end
          `NIB_DEC: begin
            d.op = OP_DEC;
            d.affects = fl(1'b0, 1'b0, 1'b1, 1'b0);
          end
          `NIB_COM: begin
            d.op = OP_COM;
            d.affects = fl(1'b0, 1'b0, 1'b1, 1'b0);
          end
          `NIB_MOV: begin
            d.op = OP_MOV;
            d.affects = fl(1'b0, 1'b0, 1'b1, 1'b0);
          end
          `NIB_RLC: begin
            d.op = OP_RLC;
            d.affects = fl(1'b1, 1'b0, 1'b0, 1'b0);
          end
          `NIB_RRC: begin
            d.op = OP_RRC;
            d.affects = fl(1'b1, 1'b0, 1'b0, 1'b0);
          end
          `NIB_SWAP: begin
            // Swap leaves every flag alone
            d.op = OP_SWAP;
          end
          `NIB_DECSZ: begin
            // Skip forms share the plain opcodes; the skip bit tells them apart
            d.op = OP_DEC;
            d.skip_on_zero = 1'b1;
          end
          `NIB_INCSZ: begin
            d.op = OP_INC;
            d.skip_on_zero = 1'b1;
          end
          `NIB_CLR: begin
            // Clear of accumulator ignores its don't-care address bits
            d.op = OP_CLR;
            d.affects = fl(1'b0, 1'b0, 1'b1, 1'b0);
            if (!w[`DEST_BIT]) begin
              d.file_addr = 7'h00;
            end
          end
          `NIB_MISC: begin
            d.dest_reg = 1'b0;
            d.dest_acc = 1'b0;
            d.src = SRC_NONE;
            if (w[`DEST_BIT]) begin
              d.op = OP_MOVWF;
              d.dest_reg = 1'b1;
            end else if (w == `WORD_RETURN) begin
              d.op = OP_RET;
              d.two_cycle = 1'b1;
            end else if (w == `WORD_RETFI) begin
              d.op = OP_RETFI;
              d.two_cycle = 1'b1;
            end else if (w == `WORD_WDCLR) begin
              d.op = OP_WDCLR;
              d.affects = fl(1'b0, 1'b0, 1'b0, 1'b1);
            end else if (w == `WORD_STANDBY) begin
              d.op = OP_SLEEP;
              d.affects = fl(1'b0, 1'b0, 1'b0, 1'b1);
            end else if (w[4:0] == 5'h00) begin
              d.op = OP_NOP;
            end
          end
        endcase
      end
      `PFX_BIT: begin
        d.src = SRC_REG;
        unique case (w[`NIB_HI:`NIB_HI-1])
          2'b00: begin
            d.op = OP_BCLR;
            d.dest_reg = 1'b1;
          end
          2'b01: begin
            d.op = OP_BSET;
            d.dest_reg = 1'b1;
          end
          2'b10: begin
            d.op = OP_BTSTC;
          end
          2'b11: begin
            d.op = OP_BTSTS;
          end
        endcase
      end
      `PFX_CTRL: begin
        d.op = w[`JUMP_SEL_BIT] ? OP_JUMP : OP_CALL;
        d.two_cycle = 1'b1;
      end
      `PFX_LIT: begin
        d.src = SRC_LIT;
        d.dest_acc = 1'b1;
        casez (nib)
          4'b111?: begin
            d.op = OP_ADD;
            d.affects = fl(1'b1, 1'b1, 1'b1, 1'b0);
          end
          4'b110?: begin
            d.op = OP_SUB;
            d.affects = fl(1'b1, 1'b1, 1'b1, 1'b0);
          end
          4'b1001: begin
            d.op = OP_AND;
            d.affects = fl(1'b0, 1'b0, 1'b1, 1'b0);
          end
          4'b1000: begin
            d.op = OP_OR;
            d.affects = fl(1'b0, 1'b0, 1'b1, 1'b0);
          end
          4'b1010: begin
            d.op = OP_XOR;
            d.affects = fl(1'b0, 1'b0, 1'b1, 1'b0);
          end
          4'b00??: begin
            // Loading a literal changes no flag
            d.op = OP_LOAD;
          end
          4'b01??: begin
            d.op = OP_RETLIT;
            d.two_cycle = 1'b1;
          end
          default: begin
            d.op = OP_ILLEGAL;
            d.dest_acc = 1'b0;
          end
        endcase
      end
    endcase
    return d;
  endfunction

  insn_latch u_latch (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .load_in(load_word),
    .squash_in(squash_next),
    .word_in(fetch_word_in),
    .word_out(cur_word)
  );

  // Skip decision uses datapath result at the last phase of the executing cycle
  always_comb begin
    squash_next = 1'b0;
    if (st_r.ex == EX_RUN && st_r.phase == `PHASE_LAST) begin
      if (st_r.dec.two_cycle) begin
        squash_next = 1'b1;
      end else if (st_r.dec.skip_on_zero && result_zero_in) begin
        squash_next = 1'b1;
      end else if (st_r.dec.op == OP_BTSTC && !tested_bit_in) begin
        squash_next = 1'b1;
      end else if (st_r.dec.op == OP_BTSTS && tested_bit_in) begin
        squash_next = 1'b1;
      end
    end
  end

  assign load_word = (st_r.phase == `PHASE_LAST);

  always_comb begin
    st_nxt = st_r;
    st_nxt.phase = st_r.phase + 2'h1;
    st_nxt.cycle_end = (st_r.phase == `PHASE_LAST - 2'h1);
    st_nxt.take = (st_r.phase == `PHASE_LAST - 2'h1);
    if (st_r.phase == `PHASE_LAST) begin
      // Decoding takes effect from the next instruction cycle
      st_nxt.dec = decode(squash_next ? `NOP_WORD : fetch_word_in);
      st_nxt.ex = squash_next ? EX_FLUSH : EX_RUN;
      st_nxt.execute = ~squash_next;
      st_nxt.nop_cycle = squash_next;
      if (squash_next) begin
        st_nxt.dec.op = OP_NOP;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
      st_r.dec.op <= OP_NOP;
      st_r.dec.src <= SRC_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign decode_out = st_r.dec;
  assign execute_out = st_r.execute;
  assign nop_cycle_out = st_r.nop_cycle;
  assign cycle_end_out = st_r.cycle_end;
  assign fetch_take_out = st_r.take;
  assign phase_out = st_r.phase;

  logic unused_word;
  assign unused_word = ^cur_word;
endmodule

// *** verif/insn_decoder_monitor.sv ***
// Purpose: port-level checks for the instruction decoder
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every decoder instance
`timescale 1ns/1ps
`include "decoder_defs.svh"
module insn_decoder_monitor
  import decoder_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [`INSN_W-1:0] fetch_word_in,
  input wire logic fetch_take_out,
  input wire logic result_zero_in,
  input wire logic tested_bit_in,
  input wire decode_s decode_out,
  input wire logic execute_out,
  input wire logic nop_cycle_out,
  input wire logic cycle_end_out,
  input wire logic [1:0] phase_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic take_run;
  logic bit_met;
  assign take_run = fetch_take_out && execute_out;
  assign bit_met = (decode_out.op == OP_BTSTC && !tested_bit_in) || (decode_out.op == OP_BTSTS && tested_bit_in);
  a_phase_steps: assert property (1'b1 |=> phase_out == $past(phase_out) + 2'h1)
    else $error("phase does not advance by one");
  a_end_phase: assert property (cycle_end_out == (phase_out == 2'h3))
    else $error("cycle end outside last phase");
  a_take_phase: assert property (fetch_take_out == cycle_end_out)
    else $error("word taken outside last phase");
  a_decode_stands: assert property (phase_out != 2'h3 |=> $stable(decode_out) && $stable(execute_out))
    else $error("decode changed inside a cycle");
  a_nop_clean: assert property (nop_cycle_out |-> !execute_out && decode_out.op == OP_NOP)
    else $error("discarded cycle not a no-operation");
  a_long_squash: assert property (take_run && decode_out.two_cycle |=> nop_cycle_out)
    else $error("second cycle not discarded");
  a_skip_zero: assert property (take_run && decode_out.skip_on_zero && result_zero_in |=> nop_cycle_out)
    else $error("zero skip not taken");
  a_bit_skip: assert property (take_run && bit_met |=> nop_cycle_out)
    else $error("bit test skip not taken");
  a_resume_run: assert property (fetch_take_out && nop_cycle_out |=> execute_out)
    else $error("no execution after discarded cycle");
  a_literal_copy: assert property (fetch_take_out && fetch_word_in[13:12] == 2'h3 && fetch_word_in[11:8] != 4'hB
    |=> nop_cycle_out || decode_out.literal == $past(fetch_word_in[7:0])) else $error("literal field not copied");
  c_long: cover property (take_run && decode_out.two_cycle);
  c_skip: cover property (take_run && decode_out.skip_on_zero && result_zero_in);
  c_bit: cover property (take_run && bit_met);
endmodule

bind insn_decoder insn_decoder_monitor i_mon (.clk_in(clk_in), .rst_n_in(rst_n_in), .fetch_word_in(fetch_word_in),
  .fetch_take_out(fetch_take_out), .result_zero_in(result_zero_in), .tested_bit_in(tested_bit_in),
  .decode_out(decode_out), .execute_out(execute_out), .nop_cycle_out(nop_cycle_out),
  .cycle_end_out(cycle_end_out), .phase_out(phase_out));

// *** verif/prog_mem_model.sv ***
// Purpose: program memory feeding one word per instruction cycle
// Assumes: the take pulse marks the edge at which the word is consumed
// Notes: word changes at the falling edge, clear of the sampling edge
`timescale 1ns/1ps
module prog_mem_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Decoder side
  input wire logic take_in,
  output logic [13:0] word_out
);
  logic [13:0] mem [256];
  logic [7:0] pc_r;
  initial word_out = 14'h0000;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_r <= 8'h00;
    end else if (take_in) begin
      pc_r <= pc_r + 8'h01;
    end
  end
  always @(negedge clk_in) begin
    word_out <= mem[pc_r];
  end
endmodule

// *** verif/insn_decoder_tb_top.sv ***
// Purpose: self-checking bench for the instruction decoder
// Assumes: memory model feeds one word per instruction cycle
// Notes: loader queues every word; the watcher pops one per new cycle
`timescale 1ns/1ps
module insn_decoder_tb_top
  import decoder_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic result_zero_in = 1'b0;
  logic tested_bit_in = 1'b0;
  logic [13:0] word, w, x;
  logic [13:0] cur = 14'h0000;
  logic fetch_take_out, execute_out, nop_cycle_out, cycle_end_out;
  logic [1:0] phase_out;
  decode_s decode_out;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  logic [13:0] q[$];
  logic squash = 1'b0;
  logic ended = 1'b0;
  op_e e;
  op_e cur_op = OP_NOP;
  op_e byte_ops[16] = '{OP_NOP, OP_CLR, OP_SUB, OP_DEC, OP_OR, OP_AND, OP_XOR, OP_ADD,
    OP_MOV, OP_COM, OP_INC, OP_DEC, OP_RRC, OP_RLC, OP_SWAP, OP_INC};
  op_e lit_ops[16] = '{OP_LOAD, OP_LOAD, OP_LOAD, OP_LOAD, OP_RETLIT, OP_RETLIT, OP_RETLIT, OP_RETLIT,
    OP_OR, OP_AND, OP_XOR, OP_ILLEGAL, OP_SUB, OP_SUB, OP_ADD, OP_ADD};
  op_e bit_ops[4] = '{OP_BCLR, OP_BSET, OP_BTSTC, OP_BTSTS};
  logic [13:0] specials[5] = '{14'h0008, 14'h0009, 14'h0064, 14'h0063, 14'h00FF};

  insn_decoder i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .fetch_word_in(word), .fetch_take_out(fetch_take_out),
    .result_zero_in(result_zero_in), .tested_bit_in(tested_bit_in), .decode_out(decode_out),
    .execute_out(execute_out), .nop_cycle_out(nop_cycle_out), .cycle_end_out(cycle_end_out), .phase_out(phase_out));
  prog_mem_model i_mem (.clk_in(clk_in), .rst_n_in(rst_n_in), .take_in(fetch_take_out), .word_out(word));

  initial forever #50 clk_in = ~clk_in;

  function automatic op_e exp_op(input logic [13:0] v);
    op_e r;
    r = lit_ops[v[11:8]];
    if (v[13:12] == 2'h2) r = v[11] ? OP_JUMP : OP_CALL;
    if (v[13:12] == 2'h1) r = bit_ops[v[11:10]];
    if (v[13:12] == 2'h0) r = byte_ops[v[11:8]];
    if (v[13:8] == 6'h00) r = v[7] ? OP_MOVWF : v[6] ? (v[0] ? OP_SLEEP : OP_WDCLR) : v[0] ? OP_RETFI : OP_RET;
    return r;
  endfunction

  function automatic flags_s exp_flags(input op_e r, input logic skz);
    flags_s f;
    f.carry = r inside {OP_ADD, OP_SUB, OP_RLC, OP_RRC};
    f.digit_carry_flag = r inside {OP_ADD, OP_SUB};
    f.zero = r inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_COM, OP_MOV, OP_CLR} || (r inside {OP_INC, OP_DEC} && !skz);
    f.timeout_flag = r inside {OP_WDCLR, OP_SLEEP};
    f.powerdown_flag = f.timeout_flag;
    return f;
  endfunction

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test();
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Skip outcome is judged from the inputs held through the last phase
  always @(negedge clk_in) begin
    if (cycle_end_out === 1'b1) begin
      squash = cur_op inside {OP_CALL, OP_JUMP, OP_RET, OP_RETLIT, OP_RETFI}
        || (cur[13:8] inside {6'h0B, 6'h0F} && result_zero_in)
        || (cur_op == OP_BTSTC && !tested_bit_in) || (cur_op == OP_BTSTS && tested_bit_in);
      ended = 1'b1;
    end else if (ended && phase_out === 2'h0 && q.size() > 0) begin
      x = q.pop_front();
      cur = squash ? 14'h0000 : x;
      cur_op = squash ? OP_NOP : exp_op(x);
      e = cur_op;
      chk(nop_cycle_out, squash);
      chk(execute_out, !squash);
      chk(decode_out.op, e);
      chk(decode_out.two_cycle, e inside {OP_CALL, OP_JUMP, OP_RET, OP_RETLIT, OP_RETFI});
      chk(decode_out.skip_on_zero, cur[13:8] inside {6'h0B, 6'h0F});
      chk(decode_out.src, cur[13:12] == 2'h3 ? SRC_LIT : (cur[13:12] == 2'h1 || (cur[13:12] == 2'h0 && cur[11:8] != 4'h0)) ? SRC_REG : SRC_NONE);
      if (e != OP_ILLEGAL) chk(decode_out.affects, exp_flags(e, cur[13:8] inside {6'h0B, 6'h0F}));
      if (cur[13:12] == 2'h0 && cur[11:9] != 3'h0) chk({decode_out.dest_reg, decode_out.dest_acc}, {cur[7], !cur[7]});
      if (cur[13:12] == 2'h1 || (cur[13:12] == 2'h0 && cur[11:9] != 3'h0)) chk(decode_out.file_addr, cur[6:0]);
      if (cur[13:12] == 2'h1) chk(decode_out.bit_sel, cur[9:7]);
      if (cur[13:12] == 2'h2) chk(decode_out.target, cur[10:0]);
      if (cur[13:12] == 2'h3 && e != OP_ILLEGAL) chk(decode_out.literal, cur[7:0]);
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      finish_test();
    end
  end

  // Opening words sweep every opcode nibble and the fixed control words
  initial begin
    w = 14'($urandom(32'h5664));
    for (int i = 0; i < 256; i++) begin
      w = 14'($urandom);
      if (i < 32) w[13:8] = {i[4] ? 2'h3 : 2'h0, i[3:0]};
      else if (i < 36) w[13:10] = {2'h1, i[1:0]};
      if (w[13:8] == 6'h00 || (i >= 36 && i < 41)) w = specials[i % 5];
      i_mem.mem[i] = w;
      q.push_back(w);
    end
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    while (q.size() > 0) begin
      @(negedge clk_in);
      if (phase_out === 2'h0) begin
        result_zero_in = 1'($urandom);
        tested_bit_in = 1'($urandom);
      end
    end
    repeat (4) @(negedge clk_in);
    finish_test();
  end
endmodule
